// ---- design/sbwb_regs.svh ----
// timing and field constants of the two-beat burst sram core
`ifndef SBWB_REGS_SVH
`define SBWB_REGS_SVH

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define SBWB_LANE_W     9
`define SBWB_MAX_LANES  4
`define SBWB_BURST_LEN  2

// ----------------------------------------------------------------
// timing, in clk cycles from the true-edge command cycle
// ----------------------------------------------------------------
`define SBWB_RD_LAT0    3
`define SBWB_RD_LAT1    4

`endif

// ---- design/sbwb_pkg.sv ----
// types of the two-beat burst sram core
package sbwb_pkg;
    typedef enum logic {
        SEQ_IDLE,
        SEQ_BEAT1
    } sbwb_seq_t;
endpackage

// ---- design/sbwb_lane_merge.sv ----
// per-lane merge of new write data over the stored word
`timescale 1ns/1ps
`default_nettype none
module sbwb_lane_merge #(
    parameter int LANES = 4,
    parameter int LW    = 9
) (
    // words
    input  wire logic [LANES*LW-1:0] old_word,
    input  wire logic [LANES*LW-1:0] new_word,
    // active-low lane enables
    input  wire logic [LANES-1:0]    lane_en_n,
    // result
    output logic      [LANES*LW-1:0] merged
);
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign merged[g*LW +: LW] = lane_en_n[g] ? old_word[g*LW +: LW]
                                                     : new_word[g*LW +: LW];
        end
    endgenerate
endmodule // sbwb_lane_merge
`default_nettype wire

// ---- design/sbwb_core.sv ----
// two-beat burst sram core with lane-masked writes
//
// Function
// - x9: lane enable low stores bits 0-8
// - x18: two lane enables gate bits 0-8, 9-17
// - x36: four lane enables, free per beat
// - internal lsb extends address as burst counter
// - fixed order: internal bit zero, then one
// - every burst ends after exactly two beats
// - read and write sequencers run concurrently
// - sequencers start only on the true-edge phase, then step every clk
// - write: address and beat0 at true edge
// - read words at true-edge plus three, four
// - both selects high: nop, outputs released
`timescale 1ns/1ps
`default_nettype none
`include "sbwb_regs.svh"
module sbwb_core #(
    parameter int LANES  = 4,
    parameter int ADDR_W = 19
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // command
    input  wire logic                  rd_sel_n,
    input  wire logic                  wr_sel_n,
    input  wire logic [ADDR_W-1:0]     rd_addr,
    input  wire logic [ADDR_W-1:0]     wr_addr,
    // write data and lane enables
    input  wire logic [LANES*9-1:0]    d,
    input  wire logic                  lane0_write_en_n,
    input  wire logic                  lane1_write_en_n,
    input  wire logic                  lane2_write_en_n,
    input  wire logic                  lane3_write_en_n,
    // read data and true-edge phase
    output logic      [LANES*9-1:0]    q,
    output logic                       q_oe_n,
    output logic                       true_phase
);
    localparam int LW = `SBWB_LANE_W;
    localparam int DW = LANES * LW;
    localparam int MA = ADDR_W + 1;

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    generate
        if (!(LANES == 1 || LANES == 2 || LANES == 4) || ADDR_W < 1) begin : g_bad
            $error("sbwb_core: LANES must be 1, 2 or 4 and ADDR_W at least 1");
        end
    endgenerate

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                phase;
        logic                s1v;
        logic [ADDR_W-1:0]   s1a;
        logic                s2v;
        logic [ADDR_W-1:0]   s2a;
        logic                s3v;
        logic [ADDR_W-1:0]   s3a;
        sbwb_pkg::sbwb_seq_t wst;
        logic [ADDR_W-1:0]   wa;
        logic [DW-1:0]       q;
        logic                qoe_n;
    } sbwb_state_t;

    sbwb_state_t st_ff;
    sbwb_state_t nxt_st;
    logic [DW-1:0] mem [0:(1<<MA)-1];

    logic [`SBWB_MAX_LANES-1:0] lane_all_n;
    logic [LANES-1:0]           lane_n;
    logic                       accept_r;
    logic                       accept_w;
    logic                       mem_we;
    logic [MA-1:0]              mem_wa;
    logic [DW-1:0]              merged;

    assign lane_all_n = {lane3_write_en_n, lane2_write_en_n,
                         lane1_write_en_n, lane0_write_en_n};
    assign lane_n     = lane_all_n[LANES-1:0];

    // commands count only on the true-edge phase
    assign accept_r = !st_ff.phase && !rd_sel_n;
    assign accept_w = !st_ff.phase && !wr_sel_n;

    // ----------------------------------------------------------------
    // write path
    // ----------------------------------------------------------------
    // beat0 writes at the command cycle itself, beat1 one cycle later
    assign mem_we = accept_w || (st_ff.wst == sbwb_pkg::SEQ_BEAT1);
    assign mem_wa = accept_w ? {wr_addr, 1'b0}
                             : {st_ff.wa, 1'b1};

    sbwb_lane_merge #(
        .LANES (LANES),
        .LW    (LW)
    ) u_merge (
        .old_word  (mem[mem_wa]),
        .new_word  (d),
        .lane_en_n (lane_n),
        .merged    (merged)
    );

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= merged;
        end
    end

    // ----------------------------------------------------------------
    // sequencers
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.phase = !st_ff.phase;
        // read address delay line: word0 fetched at s2, word1 at s3
        nxt_st.s1v   = accept_r;
        nxt_st.s1a   = rd_addr;
        nxt_st.s2v   = st_ff.s1v;
        nxt_st.s2a   = st_ff.s1a;
        nxt_st.s3v   = st_ff.s2v;
        nxt_st.s3a   = st_ff.s2a;
        nxt_st.qoe_n = 1'b1;
        if (st_ff.s2v) begin
            nxt_st.q     = mem[{st_ff.s2a, 1'b0}];
            nxt_st.qoe_n = 1'b0;
        end else if (st_ff.s3v) begin
            nxt_st.q     = mem[{st_ff.s3a, 1'b1}];
            nxt_st.qoe_n = 1'b0;
        end
        case (st_ff.wst)
            sbwb_pkg::SEQ_IDLE: begin
                if (accept_w) begin
                    nxt_st.wst = sbwb_pkg::SEQ_BEAT1;
                    nxt_st.wa  = wr_addr;
                end
            end
            sbwb_pkg::SEQ_BEAT1: begin
                nxt_st.wst = sbwb_pkg::SEQ_IDLE;
            end
            default: begin
                nxt_st.wst = sbwb_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_ff       <= '0;
            st_ff.wst   <= sbwb_pkg::SEQ_IDLE;
            st_ff.qoe_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q          = st_ff.q;
    assign q_oe_n     = st_ff.qoe_n;
    assign true_phase = !st_ff.phase;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence rd_cmd_s;
        accept_r;
    endsequence

    sequence rd_burst_s;
        !q_oe_n ##1 !q_oe_n;
    endsequence

    rd_latency_a: assert property (@(posedge clk) disable iff (!resetn)
        rd_cmd_s |-> ##3 rd_burst_s)
        else $error("read words not on cycles three and four");

    burst_end_a: assert property (@(posedge clk) disable iff (!resetn)
        rd_cmd_s ##2 !accept_r |-> ##3 q_oe_n)
        else $error("read burst longer than two beats");

    nop_release_a: assert property (@(posedge clk) disable iff (!resetn)
        !$past(accept_r, 3) && !$past(accept_r, 4) |-> q_oe_n)
        else $error("read outputs driven without a read");

    // selects on the off phase must start neither sequencer
    phase_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        st_ff.phase && (!rd_sel_n || !wr_sel_n)
        |=> !st_ff.s1v && st_ff.wst == sbwb_pkg::SEQ_IDLE)
        else $error("command taken off the true-edge phase");

    wr_two_beat_a: assert property (@(posedge clk) disable iff (!resetn)
        accept_w |=> st_ff.wst == sbwb_pkg::SEQ_BEAT1 ##1 st_ff.wst == sbwb_pkg::SEQ_IDLE)
        else $error("write burst not exactly two beats");

    lane0_store_a: assert property (@(posedge clk) disable iff (!resetn)
        accept_w && !lane_n[0]
        |=> mem[{$past(wr_addr), 1'b0}][LW-1:0] == $past(d[LW-1:0]))
        else $error("enabled lane zero not stored");

    lane0_keep_a: assert property (@(posedge clk) disable iff (!resetn)
        accept_w && lane_n[0]
        |=> mem[{$past(wr_addr), 1'b0}][LW-1:0] == $past(mem[{wr_addr, 1'b0}][LW-1:0]))
        else $error("masked lane zero changed");

    top_lane_beat1_a: assert property (@(posedge clk) disable iff (!resetn)
        st_ff.wst == sbwb_pkg::SEQ_BEAT1 && !lane_n[LANES-1]
        |=> mem[{$past(st_ff.wa), 1'b1}][LW*(LANES-1) +: LW] == $past(d[LW*(LANES-1) +: LW]))
        else $error("second beat top lane not stored at odd word");

    concurrent_a: assert property (@(posedge clk) disable iff (!resetn)
        accept_r && accept_w |-> ##3 !q_oe_n)
        else $error("write blocked a concurrent read");

    // the odd word of the last burst is what a stray write would hit
    lane_ignore_a: assert property (@(posedge clk) disable iff (!resetn)
        !accept_w && st_ff.wst == sbwb_pkg::SEQ_IDLE && !lane_n[0]
        |=> mem[{$past(st_ff.wa), 1'b1}] == $past(mem[{st_ff.wa, 1'b1}]))
        else $error("memory written outside a write burst");
endmodule // sbwb_core
`default_nettype wire

// ---- bench/sbwb_ctrl_model.sv ----
// memory controller model driving commands and write beats
`timescale 1ns/1ps
`default_nettype none
module sbwb_ctrl_model #(
    parameter int AW = 4
) (
    // timing
    input  wire logic          clk,
    input  wire logic          true_phase,
    // command and data
    output logic               rd_sel_n,
    output logic               wr_sel_n,
    output logic [AW-1:0]      rd_addr,
    output logic [AW-1:0]      wr_addr,
    output logic [35:0]        d,
    output logic [3:0]         lane_n
);
    initial begin
        rd_sel_n = 1'b1;
        wr_sel_n = 1'b1;
        rd_addr  = '0;
        wr_addr  = '0;
        d        = '0;
        lane_n   = 4'hf;
    end
    task automatic wr(input logic [AW-1:0] a, input logic [71:0] dd, input logic [7:0] ll);
        do @(negedge clk); while (true_phase !== 1'b1);
        wr_sel_n = 1'b0;
        wr_addr  = a;
        d        = dd[35:0];
        lane_n   = ll[3:0];
        @(negedge clk);
        wr_sel_n = 1'b1;
        wr_addr  = ~a;
        d        = dd[71:36];
        lane_n   = ll[7:4];
        @(negedge clk);
        // inverted, so a stale beat cannot pass for data
        d        = ~d;
        lane_n   = ~lane_n;
    endtask
    task automatic rd(input logic [AW-1:0] a);
        do @(negedge clk); while (true_phase !== 1'b1);
        rd_sel_n = 1'b0;
        rd_addr  = a;
        @(negedge clk);
        rd_sel_n = 1'b1;
        rd_addr  = ~a;
    endtask
    // commanded fault: selects low on the off phase
    task automatic stray(input logic [AW-1:0] a);
        do @(negedge clk); while (true_phase !== 1'b0);
        rd_sel_n = 1'b0;
        wr_sel_n = 1'b0;
        rd_addr  = a;
        wr_addr  = a;
        lane_n   = 4'h0;
        @(negedge clk);
        rd_sel_n = 1'b1;
        wr_sel_n = 1'b1;
    endtask
endmodule // sbwb_ctrl_model
`default_nettype wire

// ---- bench/test_sram_byte_write_burst.sv ----
// self-checking bench of the two-beat burst sram core
`timescale 1ns/1ps
`default_nettype none
module test_sram_byte_write_burst;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic rd_sel_n, wr_sel_n, q_oe_n, true_phase;
    logic [3:0] rd_addr, wr_addr, lane_n;
    logic [35:0] d, q;
    logic [35:0] mem [32];
    int error_cnt = 0;
    int n_checks = 0;
    always #2 clk = ~clk;
    sbwb_ctrl_model #(.AW(4)) sbwb_ctrl_model_inst (.clk(clk), .true_phase(true_phase),
        .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .rd_addr(rd_addr), .wr_addr(wr_addr),
        .d(d), .lane_n(lane_n));
    sbwb_core #(.LANES(4), .ADDR_W(4)) sbwb_core_inst (.clk(clk), .resetn(resetn),
        .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .rd_addr(rd_addr), .wr_addr(wr_addr),
        .d(d), .lane0_write_en_n(lane_n[0]), .lane1_write_en_n(lane_n[1]),
        .lane2_write_en_n(lane_n[2]), .lane3_write_en_n(lane_n[3]),
        .q(q), .q_oe_n(q_oe_n), .true_phase(true_phase));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic w(input logic [3:0] a, input logic [35:0] d0, input logic [3:0] l0,
                     input logic [35:0] d1, input logic [3:0] l1);
        sbwb_ctrl_model_inst.wr(a, {d1, d0}, {l1, l0});
        for (int n = 0; n < 4; n++) begin
            if (!l0[n]) mem[{a, 1'b0}][9*n+:9] = d0[9*n+:9];
            if (!l1[n]) mem[{a, 1'b1}][9*n+:9] = d1[9*n+:9];
        end
    endtask
    task automatic rd_chk(input logic [3:0] a);
        sbwb_ctrl_model_inst.rd(a);
        repeat (2) @(negedge clk);
        chk(q_oe_n, 1'b0);
        chk(q, mem[{a, 1'b0}]);
        @(negedge clk);
        chk(q_oe_n, 1'b0);
        chk(q, mem[{a, 1'b1}]);
        @(negedge clk);
        chk(q_oe_n, 1'b1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_full();
        chk(true_phase, 1'b1);
        chk(q_oe_n, 1'b1);
        w(4'h1, 36'h123456789, 4'h0, 36'hfedcba987, 4'h0);
        rd_chk(4'h1);
        $display("test full done");
    endtask
    task automatic t_lanes();
        w(4'hd, 36'h2468ace13, 4'h0, 36'h13579bdf0, 4'h0);
        for (int n = 0; n <= 4; n++) begin
            w(4'h2, 36'h0, 4'h0, 36'h0, 4'h0);
            w(4'h2, 36'hfffffffff, ~(4'h1 << n), 36'h5a5a5a5a5, ~(4'h8 >> n));
            rd_chk(4'h2);
        end
        // lanes now all low at address d with no write select
        rd_chk(4'hd);
        $display("test lanes done");
    endtask
    task automatic t_conc();
        fork
            w(4'h3, 36'h0f0f0f0f0, 4'h0, 36'h00ff00ff0, 4'h0);
            rd_chk(4'h1);
        join
        rd_chk(4'h3);
        $display("test concurrent done");
    endtask
    task automatic t_refuse();
        sbwb_ctrl_model_inst.stray(4'h1);
        repeat (6) begin
            @(negedge clk);
            chk(q_oe_n, 1'b1);
        end
        rd_chk(4'h1);
        $display("test refuse done");
    endtask
    initial begin
        #20000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        t_full();
        t_lanes();
        t_conc();
        t_refuse();
        print_verdict();
    end
endmodule // test_sram_byte_write_burst
`default_nettype wire
